// *** cmdv_regs.svh ***
// Constants for the cascadable multiply/divide unit: register selects,
// control word fields, status layout and shift sequencing figures.
// Assumes inclusion by bare name from every file that needs them.
`ifndef CMDV_REGS_SVH
`define CMDV_REGS_SVH

// Register select codes on reg_sel_1/reg_sel_0.
`define CMDV_SEL_DIVISOR 2'h0
`define CMDV_SEL_LOW     2'h1
`define CMDV_SEL_HIGH    2'h2
`define CMDV_SEL_CTRL    2'h3

// Control word bit positions.
`define CMDV_CTL_MUL     0
`define CMDV_CTL_DIV     1
`define CMDV_CTL_LRST    2
`define CMDV_CTL_HRST    3
`define CMDV_CTL_NLO     4
`define CMDV_CTL_NHI     5
`define CMDV_CTL_SEQRST  6
`define CMDV_CTL_PRESC   7

// Reset values.
`define CMDV_CTRL_RESET  8'h00
`define CMDV_SEQ_LEAD    2'h3

// Status byte: overflow flag position, other bits read as zero.
`define CMDV_STAT_OVF    0

// Bits per unit, and the one extra settle pulse of each operation.
`define CMDV_UNIT_BITS   6'h08
`define CMDV_EXTRA_PULSE 6'h01
`define CMDV_UNITS_MAX   3'h4

`endif

// *** cmdv_pkg.sv ***
// Types shared by the multiply/divide unit's modules.
// Assumes nothing beyond a SystemVerilog compiler.
package cmdv_pkg;

  // Operation state of the datapath, one-hot.
  typedef enum logic [2:0] {
    CMDV_ST_IDLE = 3'b001,
    CMDV_ST_MUL  = 3'b010,
    CMDV_ST_DIV  = 3'b100
  } cmdv_state_t;

  // Unit-count code as held in the control word.
  typedef logic [1:0] cmdv_ucode_t;

endpackage

// *** cmdv_shift_if.sv ***
// Interface between the unit's core and its shift pulse generator.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
`default_nettype none
interface cmdv_shift_if;
  logic                 start;
  logic                 clear;
  logic                 presc_en;
  logic                 tick;
  cmdv_pkg::cmdv_ucode_t ucode;
  logic                 step;
  logic                 first;
  logic                 busy;
  logic                 shift_lvl;

  modport gen (input start, input clear, input presc_en, input tick,
               input ucode, output step, output first, output busy,
               output shift_lvl);
  modport core (output start, output clear, output presc_en, output tick,
                output ucode, input step, input first, input busy,
                input shift_lvl);
endinterface
`default_nettype wire

// *** cmdv_sync.sv ***
// Three-stage synchroniser for pin inputs; a bit changes once the second
// and third stages agree. Assumes inputs are asynchronous to clk.
`timescale 1ns/10ps
`default_nettype none
module cmdv_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_nxt;

  // Take the new level only where the last two stages agree.
  always_comb begin
    q_nxt = (q & (s2_r ^ s3_r)) | (s2_r & ~(s2_r ^ s3_r));
  end

  // Stage registers; the first stage feeds only the second.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q    <= '0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q    <= q_nxt;
    end
  end
endmodule
`default_nettype wire

// *** cmdv_shiftgen.sv ***
// Shift pulse generator: after a start, issues 8N+1 steps, one per tick
// or one per prescaled group of ticks. Assumes ticks are one-cycle pulses.
`timescale 1ns/10ps
`default_nettype none
`include "cmdv_regs.svh"
module cmdv_shiftgen (
  input  wire logic  clk,
  input  wire logic  rst_n,
  cmdv_shift_if.gen  sh
);
  logic [5:0] rem_r;
  logic [5:0] rem_nxt;
  logic [2:0] pre_r;
  logic [2:0] pre_nxt;
  logic       step_r;
  logic       step_nxt;
  logic       first_r;
  logic       first_nxt;
  logic       lvl_r;
  logic       lvl_nxt;

  // Total pulses of one operation for a unit-count code.
  function automatic logic [5:0] total_f(input cmdv_pkg::cmdv_ucode_t c);
    logic [2:0] n;
    n = `CMDV_UNITS_MAX - {1'b0, c};
    total_f = (`CMDV_UNIT_BITS * {3'h0, n}) + `CMDV_EXTRA_PULSE;
  endfunction

  // Last prescaler count before a step: 1, 2, 4 or 8 ticks per step.
  function automatic logic [2:0] div_f(input logic en,
                                       input cmdv_pkg::cmdv_ucode_t c);
    div_f = !en ? 3'h0 : (c == 2'h3) ? 3'h1 : (c == 2'h2) ? 3'h3 : 3'h7;
  endfunction

  // Next-state of the pulse counter and prescaler.
  always_comb begin
    rem_nxt   = rem_r;
    pre_nxt   = pre_r;
    step_nxt  = 1'b0;
    first_nxt = 1'b0;
    lvl_nxt   = lvl_r;
    if (sh.clear) begin
      rem_nxt = 6'h00;
      pre_nxt = 3'h0;
    end else if (sh.start) begin
      rem_nxt = total_f(sh.ucode);
      pre_nxt = 3'h0;
    end else if (sh.tick && rem_r != 6'h00) begin
      if (pre_r == div_f(sh.presc_en, sh.ucode)) begin
        pre_nxt   = 3'h0;
        step_nxt  = 1'b1;
        first_nxt = (rem_r == total_f(sh.ucode));
        rem_nxt   = rem_r - 6'h01;
        lvl_nxt   = ~lvl_r;
      end else begin
        pre_nxt = pre_r + 3'h1;
      end
    end
  end

  // Register the generator state.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rem_r   <= 6'h00;
      pre_r   <= 3'h0;
      step_r  <= 1'b0;
      first_r <= 1'b0;
      lvl_r   <= 1'b0;
    end else begin
      rem_r   <= rem_nxt;
      pre_r   <= pre_nxt;
      step_r  <= step_nxt;
      first_r <= first_nxt;
      lvl_r   <= lvl_nxt;
    end
  end

  assign sh.step      = step_r;
  assign sh.first     = first_r;
  assign sh.busy      = (rem_r != 6'h00) | step_r;
  assign sh.shift_lvl = lvl_r;
endmodule
`default_nettype wire

// *** cmdv_top.sv ***
// One cascadable 8-bit unsigned multiply/divide unit with its host pins,
// chain pins and shift pin. Assumes all pins are asynchronous to clk and
// that op_clock_in and the shift pin run well below clk/8.
`timescale 1ns/10ps
`default_nettype none
`include "cmdv_regs.svh"
module cmdv_top (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       unit_select,
  input  wire logic       reg_sel_2,
  input  wire logic       reg_sel_1,
  input  wire logic       reg_sel_0,
  input  wire logic       read_write_sel,
  input  wire logic       strobe,
  input  wire logic       clear_n,
  input  wire logic [7:0] bus_in,
  output logic      [7:0] bus_out,
  output logic            bus_oe,
  input  wire logic       position_id_1,
  input  wire logic       position_id_0,
  input  wire logic       op_clock_in,
  input  wire logic       shift_only_ctrl,
  input  wire logic       shift_in,
  output logic            shift_out,
  output logic            shift_oe,
  output logic            carry_overflow_out,
  output logic            carry_overflow_oe,
  input  wire logic       upper_chain_left_in,
  output logic            upper_chain_left_out,
  output logic            upper_chain_left_oe,
  input  wire logic       upper_chain_right_in,
  output logic            upper_chain_right_out,
  output logic            upper_chain_right_oe,
  input  wire logic       lower_chain_left_in,
  output logic            lower_chain_left_out,
  output logic            lower_chain_left_oe,
  input  wire logic       lower_chain_right_in,
  output logic            lower_chain_right_out,
  output logic            lower_chain_right_oe
);
  ////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisation.
  ////////////////////////////////////////////////////////////////////////////
  logic        rst_meta_r;
  logic        rst_n;
  logic [23:0] pin_raw;
  logic [23:0] pin_q;

  // Release the asynchronous reset through two flip-flops.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  // Every host, strap and chain pin passes the three-stage synchroniser.
  assign pin_raw = {strobe, read_write_sel, reg_sel_2, reg_sel_1, reg_sel_0,
                    unit_select, clear_n, bus_in, position_id_1,
                    position_id_0, op_clock_in, shift_in, shift_only_ctrl,
                    upper_chain_left_in, upper_chain_right_in,
                    lower_chain_left_in, lower_chain_right_in};

  cmdv_sync #(.W(24)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (pin_raw),
    .q     (pin_q)
  );

  logic       s_stb;
  logic       s_rw;
  logic       s_rs2;
  logic [1:0] s_sel;
  logic       s_us;
  logic       s_clr_n;
  logic [7:0] s_bus;
  logic [1:0] s_pos;
  logic       s_opclk;
  logic       s_shin;
  logic       s_ctrl;
  logic       s_ucl;
  logic       s_ucr;
  logic       s_lcl;
  logic       s_lcr;

  // Split the synchronised vector back into named levels.
  assign {s_stb, s_rw, s_rs2, s_sel, s_us, s_clr_n, s_bus, s_pos, s_opclk,
          s_shin, s_ctrl, s_ucl, s_ucr, s_lcl, s_lcr} = pin_q;

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection and shift generator.
  ////////////////////////////////////////////////////////////////////////////
  logic stb_prev_r;
  logic opclk_prev_r;
  logic shin_prev_r;
  logic stb_fall;
  logic lead;
  logic trail;
  logic sel_ok;
  logic match;

  // Previous stable levels for edge detection.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stb_prev_r   <= 1'b0;
      opclk_prev_r <= 1'b0;
      shin_prev_r  <= 1'b0;
    end else begin
      stb_prev_r   <= s_stb;
      opclk_prev_r <= s_opclk;
      shin_prev_r  <= s_shin;
    end
  end

  logic [7:0]               ctrl_r;
  logic [1:0]               seq_r;
  cmdv_pkg::cmdv_ucode_t    ucode;
  logic                     start_c;
  cmdv_shift_if             sh ();

  // Strobe fall, access gating and unit position decoding.
  assign stb_fall = stb_prev_r & ~s_stb;
  assign sel_ok   = s_us & s_rs2;
  assign match    = (seq_r == s_pos);
  assign lead     = (s_pos == `CMDV_SEQ_LEAD);
  assign ucode    = ctrl_r[`CMDV_CTL_NHI:`CMDV_CTL_NLO];
  assign trail    = (s_pos == ucode);

  // The lead unit times from the clock pin, the others from the shift pin.
  assign sh.tick     = lead ? (s_opclk & ~opclk_prev_r)
                            : (s_shin ^ shin_prev_r);
  assign sh.presc_en = lead & ctrl_r[`CMDV_CTL_PRESC];
  assign sh.ucode    = ucode;
  assign sh.clear    = ~s_clr_n;
  assign sh.start    = start_c;

  cmdv_shiftgen u_gen (
    .clk   (clk),
    .rst_n (rst_n),
    .sh    (sh.gen)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Registers, sequence counter and datapath.
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0]            divisor_r;
  logic [7:0]            divisor_nxt;
  logic [7:0]            hi_r;
  logic [7:0]            hi_nxt;
  logic [7:0]            lo_r;
  logic [7:0]            lo_nxt;
  logic [7:0]            ctrl_nxt;
  logic                  ovf_r;
  logic                  ovf_nxt;
  logic [1:0]            seq_nxt;
  cmdv_pkg::cmdv_state_t state_r;
  cmdv_pkg::cmdv_state_t state_nxt;
  logic [8:0]            sum9;
  logic [8:0]            sh9;
  logic                  op_div;
  logic [7:0]            hi_eff;

  // Multiply step: add divisor when operating, then shift right.
  assign sum9 = {1'b0, hi_r} + (s_ctrl ? {1'b0, divisor_r} : 9'h000);
  // Divide step: shift left taking the chain bit, subtract when it fits.
  assign sh9    = {hi_r, s_ucr};
  assign op_div = s_ctrl | (sh9[7:0] >= divisor_r);
  // High register as it will stand after the control word's reset bit.
  assign hi_eff = s_bus[`CMDV_CTL_HRST] ? 8'h00 : hi_r;

  // Next values of the operand registers, control word and counter.
  always_comb begin
    divisor_nxt = divisor_r;
    hi_nxt      = hi_r;
    lo_nxt      = lo_r;
    ctrl_nxt    = ctrl_r;
    ovf_nxt     = ovf_r;
    seq_nxt     = seq_r;
    state_nxt   = state_r;
    start_c     = 1'b0;
    if (!s_clr_n) begin
      seq_nxt   = `CMDV_SEQ_LEAD;
      ctrl_nxt[`CMDV_CTL_DIV:`CMDV_CTL_MUL] = 2'h0;
      state_nxt = cmdv_pkg::CMDV_ST_IDLE;
    end else begin
      if (stb_fall && sel_ok) begin
        seq_nxt = seq_r - 2'h1;
      end
      if (sh.step && !sh.first) begin
        case (state_r)
          cmdv_pkg::CMDV_ST_MUL: begin
            hi_nxt = {lead ? sum9[8] : s_ucl, sum9[7:1]};
            lo_nxt = {(lead && trail) ? sum9[0] : s_lcl, lo_r[7:1]};
          end
          cmdv_pkg::CMDV_ST_DIV: begin
            hi_nxt = op_div ? (sh9[7:0] - divisor_r) : sh9[7:0];
            lo_nxt = {lo_r[6:0], trail ? op_div : s_lcr};
          end
          default: begin
            hi_nxt = hi_r;
          end
        endcase
      end
      if (stb_fall && sel_ok && !s_rw) begin
        case (s_sel)
          `CMDV_SEL_CTRL: begin
            ctrl_nxt = s_bus;
            ovf_nxt  = (divisor_r <= hi_eff);
            if (s_bus[`CMDV_CTL_LRST]) begin
              lo_nxt = 8'h00;
            end
            if (s_bus[`CMDV_CTL_HRST]) begin
              hi_nxt = 8'h00;
            end
            if (s_bus[`CMDV_CTL_SEQRST]) begin
              seq_nxt = `CMDV_SEQ_LEAD;
            end
            if (s_bus[`CMDV_CTL_MUL]) begin
              state_nxt = cmdv_pkg::CMDV_ST_MUL;
              start_c   = 1'b1;
            end else if (s_bus[`CMDV_CTL_DIV]) begin
              state_nxt = cmdv_pkg::CMDV_ST_DIV;
              start_c   = 1'b1;
            end
          end
          `CMDV_SEL_DIVISOR: begin
            if (match) begin
              divisor_nxt = s_bus;
            end
          end
          `CMDV_SEL_LOW: begin
            if (match) begin
              lo_nxt = s_bus;
            end
          end
          default: begin
            if (match) begin
              hi_nxt = s_bus;
            end
          end
        endcase
      end
      if (!start_c && state_r != cmdv_pkg::CMDV_ST_IDLE && !sh.busy) begin
        state_nxt = cmdv_pkg::CMDV_ST_IDLE;
      end
    end
  end

  // Register the operand, control and sequence state.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      divisor_r <= 8'h00;
      hi_r      <= 8'h00;
      lo_r      <= 8'h00;
      ctrl_r    <= `CMDV_CTRL_RESET;
      ovf_r     <= 1'b0;
      seq_r     <= `CMDV_SEQ_LEAD;
      state_r   <= cmdv_pkg::CMDV_ST_IDLE;
    end else begin
      divisor_r <= divisor_nxt;
      hi_r      <= hi_nxt;
      lo_r      <= lo_nxt;
      ctrl_r    <= ctrl_nxt;
      ovf_r     <= ovf_nxt;
      seq_r     <= seq_nxt;
      state_r   <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers, all registered.
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] bus_out_nxt;
  logic       bus_oe_nxt;
  logic       mul_dir;

  // Right pins drive only while a multiply runs; left pins drive otherwise.
  assign mul_dir = (state_r == cmdv_pkg::CMDV_ST_MUL);

  // Bus read data, and the bus output enable.
  always_comb begin
    bus_oe_nxt = sel_ok & s_rw & match;
    case (s_sel)
      `CMDV_SEL_DIVISOR: bus_out_nxt = divisor_r;
      `CMDV_SEL_LOW:     bus_out_nxt = lo_r;
      `CMDV_SEL_HIGH:    bus_out_nxt = hi_r;
      default:           bus_out_nxt = {7'h00, ovf_r};
    endcase
  end

  // Output flip-flops for bus, overflow, shift and chain pins.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_out               <= 8'h00;
      bus_oe                <= 1'b0;
      carry_overflow_out    <= 1'b1;
      carry_overflow_oe     <= 1'b0;
      shift_out             <= 1'b0;
      shift_oe              <= 1'b0;
      upper_chain_left_out  <= 1'b0;
      upper_chain_left_oe   <= 1'b0;
      lower_chain_left_out  <= 1'b0;
      lower_chain_left_oe   <= 1'b0;
      upper_chain_right_out <= 1'b0;
      upper_chain_right_oe  <= 1'b0;
      lower_chain_right_out <= 1'b0;
      lower_chain_right_oe  <= 1'b0;
    end else begin
      bus_out               <= bus_out_nxt;
      bus_oe                <= bus_oe_nxt;
      carry_overflow_out    <= lead ? ~ovf_r : 1'b1;
      carry_overflow_oe     <= lead ? s_us : 1'b1;
      shift_out             <= sh.shift_lvl;
      shift_oe              <= lead;
      upper_chain_left_out  <= hi_r[7];
      upper_chain_left_oe   <= ~mul_dir;
      lower_chain_left_out  <= lo_r[7];
      lower_chain_left_oe   <= ~mul_dir;
      upper_chain_right_out <= hi_r[0];
      upper_chain_right_oe  <= mul_dir;
      lower_chain_right_out <= lo_r[0];
      lower_chain_right_oe  <= mul_dir;
    end
  end
endmodule
`default_nettype wire

// *** cmdv_chk.sv ***
// Checker for one lead multiply/divide unit, watching its top pins.
// Assumes one clock domain and the active-low reset_n of the top.
`timescale 1ns/10ps
`default_nettype none
module cmdv_chk (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       unit_select,
  input wire logic       reg_sel_2,
  input wire logic       reg_sel_1,
  input wire logic       reg_sel_0,
  input wire logic       read_write_sel,
  input wire logic       strobe,
  input wire logic [7:0] bus_out,
  input wire logic       bus_oe,
  input wire logic       shift_out,
  input wire logic       carry_overflow_out,
  input wire logic       carry_overflow_oe,
  input wire logic       upper_chain_left_oe,
  input wire logic       upper_chain_right_oe,
  input wire logic       lower_chain_left_oe,
  input wire logic       lower_chain_right_oe
);
  logic [3:0] idle_r;
  logic [5:0] steps_r;
  wire        en = unit_select && reg_sel_2;
  wire  [1:0] rs = {reg_sel_1, reg_sel_0};

  // Counts idle cycles, and shift steps since the last control write.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      idle_r  <= 4'h0;
      steps_r <= 6'h00;
    end else begin
      idle_r <= en ? 4'h0 : idle_r + {3'h0, idle_r != 4'hf};
      if ($fell(strobe) && en && !read_write_sel && rs == 2'h3)
        steps_r <= 6'h00;
      else if ($changed(shift_out) && steps_r != 6'h3f)
        steps_r <= steps_r + 6'h01;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  chain_dir_a: assert property (
    upper_chain_right_oe == lower_chain_right_oe &&
    !(upper_chain_right_oe && upper_chain_left_oe) &&
    upper_chain_left_oe == lower_chain_left_oe) else $error("chain dir");
  read_gate_a: assert property (
    $rose(bus_oe) |-> $past(en && read_write_sel, 3))
    else $error("bus driven unselected");
  idle_float_a: assert property (
    idle_r > 4'h8 |-> !bus_oe) else $error("bus not floating");
  status_zero_a: assert property (
    bus_oe && $past(rs, 8) == 2'h3 && $past(rs, 2) == 2'h3
    |-> bus_out[7:1] == 7'h00) else $error("status high bits set");
  ovf_on_a: assert property (
    $rose(unit_select) |-> ##[3:8] carry_overflow_oe)
    else $error("overflow pin not enabled");
  ovf_off_a: assert property (
    $fell(unit_select) |-> ##[3:8] !carry_overflow_oe)
    else $error("overflow pin not released");
  step_gap_a: assert property (
    $changed(shift_out) |=> $stable(shift_out)[*6])
    else $error("shift steps too close");
  step_count_a: assert property (
    steps_r <= 6'h21) else $error("too many shift steps");

  cover property ($rose(bus_oe));
  cover property (carry_overflow_oe && !carry_overflow_out);
  cover property ($changed(shift_out));
endmodule

bind cmdv_top cmdv_chk chk_u (.clk, .reset_n, .unit_select, .reg_sel_2,
  .reg_sel_1, .reg_sel_0, .read_write_sel, .strobe, .bus_out, .bus_oe,
  .shift_out, .carry_overflow_out, .carry_overflow_oe, .upper_chain_left_oe,
  .upper_chain_right_oe, .lower_chain_left_oe, .lower_chain_right_oe);
`default_nettype wire

// *** cmdv_host_model.sv ***
// Host processor model driving the unit's bus pins and operation clock.
// Assumes the bench calls its tasks one at a time.
`timescale 1ns/10ps
`default_nettype none
module cmdv_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] bus_out,
  input  wire logic       bus_oe,
  output logic            unit_select,
  output logic            reg_sel_2,
  output logic            reg_sel_1,
  output logic            reg_sel_0,
  output logic            read_write_sel,
  output logic            strobe,
  output logic            clear_n,
  output logic            op_clock_in,
  output logic      [7:0] bus_in
);
  int oc_n = 0;

  // Levels at time zero: enabled, nothing selected, strobe high.
  initial begin
    {unit_select, reg_sel_2, reg_sel_1, reg_sel_0} = 4'h8;
    {read_write_sel, strobe, clear_n, op_clock_in} = 4'he;
    bus_in = 8'h00;
  end

  // Free-running operation clock of ten system clocks.
  always @(negedge clk) begin
    oc_n = (oc_n + 1) % 5;
    if (oc_n == 0)
      op_clock_in = !op_clock_in;
  end

  // One access: selects settle, strobe pulses, the bus is released.
  task automatic acc(input logic rd, input logic [1:0] sel,
                     input logic [7:0] d, output logic [8:0] q);
    @(negedge clk);
    {reg_sel_2, reg_sel_1, reg_sel_0, read_write_sel} = {1'b1, sel, rd};
    bus_in = rd ? ~bus_in : d;
    repeat (8) @(negedge clk);
    q = {bus_oe, bus_out};
    strobe = 1'b0;
    repeat (8) @(negedge clk);
    strobe = 1'b1;
    repeat (8) @(negedge clk);
    reg_sel_2 = 1'b0;
    bus_in = ~bus_in;
    repeat (8) @(negedge clk);
  endtask

  // Clear pulse: puts the counter back on the lead unit.
  task automatic clr();
    @(negedge clk);
    clear_n = 1'b0;
    repeat (6) @(negedge clk);
    clear_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask

  // Unit enable, held long enough for the pins to settle.
  task automatic enable(input logic v);
    @(negedge clk);
    unit_select = v;
    repeat (10) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Bench for one lead multiply/divide unit driven by the host model.
// Assumes the design, checker and host model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       unit_select, reg_sel_2, reg_sel_1, reg_sel_0, strobe;
  logic       read_write_sel, clear_n, op_clock_in, bus_oe, shift_out;
  logic [7:0] bus_in, bus_out;
  logic       shift_oe, carry_overflow_out, carry_overflow_oe;
  logic       upper_chain_left_out, upper_chain_left_oe;
  logic       upper_chain_right_out, upper_chain_right_oe;
  logic       lower_chain_left_out, lower_chain_left_oe;
  logic       lower_chain_right_out, lower_chain_right_oe;
  logic [8:0] q;
  int         n_mismatch = 0;
  int         checks_done = 0;
  // One-unit ring: net_a joins upper-left, lower-right and operate line.
  wire net_a = lower_chain_right_oe ? lower_chain_right_out :
               upper_chain_left_oe ? upper_chain_left_out : 1'b0;
  wire net_b = upper_chain_right_oe ? upper_chain_right_out :
               lower_chain_left_oe ? lower_chain_left_out : 1'b0;
  wire shift_lvl = shift_oe ? shift_out : 1'b0;

  always #2 clk = ~clk;

  cmdv_host_model host_u (.clk, .bus_out, .bus_oe, .unit_select,
    .reg_sel_2, .reg_sel_1, .reg_sel_0, .read_write_sel, .strobe,
    .clear_n, .op_clock_in, .bus_in);
  cmdv_top dut_u (.clk, .reset_n, .unit_select, .reg_sel_2, .reg_sel_1,
    .reg_sel_0, .read_write_sel, .strobe, .clear_n, .bus_in, .bus_out,
    .bus_oe, .position_id_1(1'b1), .position_id_0(1'b1), .op_clock_in,
    .shift_only_ctrl(net_a), .shift_in(shift_lvl), .shift_out, .shift_oe,
    .carry_overflow_out, .carry_overflow_oe, .upper_chain_left_in(net_a),
    .upper_chain_left_out, .upper_chain_left_oe, .upper_chain_right_oe,
    .upper_chain_right_in(net_b), .upper_chain_right_out,
    .lower_chain_left_in(net_b), .lower_chain_left_out,
    .lower_chain_left_oe, .lower_chain_right_in(net_a),
    .lower_chain_right_out, .lower_chain_right_oe);

  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Counter back to the lead unit, then one register load.
  task automatic put(input logic [1:0] sel, input logic [7:0] d);
    host_u.acc(1'b0, 2'h3, 8'h70, q);
    host_u.acc(1'b0, sel, d, q);
  endtask

  // Read of one register; status is read without a counter reset.
  task automatic get(input logic [1:0] sel, input logic [7:0] exp);
    if (sel != 2'h3)
      host_u.acc(1'b0, 2'h3, 8'h70, q);
    host_u.acc(1'b1, sel, 8'h00, q);
    check(q, {1'b1, exp});
  endtask

  // Control write; counts shift steps, their span and chain direction.
  task automatic op(input logic [7:0] cw, input int span);
    int n = 0;
    int t0 = 0;
    int t1 = 0;
    logic s = shift_out;
    logic [2:0] dir = 3'h0;
    fork
      host_u.acc(1'b0, 2'h3, cw, q);
      for (int i = 0; i < 600; i++) begin
        @(negedge clk);
        if (shift_out !== s) begin
          if (n == 0)
            t0 = i;
          if (n == 0)
            dir = {upper_chain_right_oe, lower_chain_right_oe,
                   upper_chain_left_oe};
          t1 = i;
          n++;
          s = shift_out;
        end
      end
    join
    check(9'(n), 9'h009);
    check(9'(t1 - t0), 9'(span));
    check({6'h00, dir}, cw[0] ? 9'h006 : 9'h001);
    check({6'h00, upper_chain_right_oe, lower_chain_right_oe,
           upper_chain_left_oe}, 9'h001);
  endtask

  // Main sequence: reset, counter walk, multiply, divide, overflow.
  initial begin
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    host_u.clr();
    put(2'h0, 8'haa);
    host_u.acc(1'b0, 2'h0, 8'h55, q);
    get(2'h0, 8'haa);
    host_u.acc(1'b1, 2'h0, 8'h00, q);
    check({8'h00, q[8]}, 9'h000);
    host_u.clr();
    host_u.acc(1'b1, 2'h0, 8'h00, q);
    check(q, 9'h1aa);
    put(2'h0, 8'hd7);
    put(2'h1, 8'h9b);
    put(2'h2, 8'h5c);
    op(8'h79, 80);
    get(2'h2, 8'h82);
    get(2'h1, 8'h2d);
    get(2'h0, 8'hd7);
    put(2'h1, 8'h9b);
    op(8'hf1, 160);
    get(2'h2, 8'h82);
    get(2'h1, 8'haf);
    put(2'h0, 8'h5a); // nonzero divisor
    put(2'h2, 8'h12);
    put(2'h1, 8'h34);
    op(8'h72, 80);
    get(2'h3, 8'h00);
    check({7'h00, carry_overflow_oe, carry_overflow_out}, 9'h003);
    get(2'h1, 8'h33);
    get(2'h2, 8'h46);
    get(2'h0, 8'h5a);
    host_u.acc(1'b0, 2'h3, 8'h74, q);
    get(2'h1, 8'h00);
    put(2'h0, 8'h10);
    put(2'h2, 8'h20);
    op(8'h72, 80);
    get(2'h3, 8'h01);
    check({7'h00, carry_overflow_oe, carry_overflow_out}, 9'h002);
    put(2'h2, 8'h00);
    put(2'h1, 8'h20);
    op(8'h72, 80);
    get(2'h1, 8'h02);
    put(2'h1, 8'h34);
    op(8'h72, 80);
    get(2'h1, 8'h03);
    get(2'h2, 8'h04);
    host_u.enable(1'b0);
    check({8'h00, carry_overflow_oe}, 9'h000);
    host_u.acc(1'b1, 2'h3, 8'h00, q);
    check({8'h00, q[8]}, 9'h000);
    host_u.enable(1'b1);
    final_report();
  end

  // Watchdog: the sequence needs well under 20000 clocks.
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    final_report();
  end
endmodule
`default_nettype wire
